/* plm_map.svh */
// Opcode, function code and reset value constants for the privileged library mode unit
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH

// ==========================================================
// Major opcodes
`define PLM_OP_CALL        6'h00
`define PLM_OP_RES_ZERO    6'h19
`define PLM_OP_RES_ONE     6'h1B
`define PLM_OP_RES_TWO     6'h1D
`define PLM_OP_RES_THREE   6'h1E
`define PLM_OP_RES_FOUR    6'h1F

// ==========================================================
// Call function codes
`define PLM_FN_HALT        26'h000_0000
`define PLM_FN_DRAIN       26'h000_0002
`define PLM_FN_BREAK       26'h000_0080
`define PLM_FN_BUG_CHECK_TRAP_CALL      26'h000_0081
`define PLM_FN_GENERIC_TRAP_CALL     26'h000_00AA
`define PLM_FN_IBARRIER    26'h000_0086
`define PLM_FN_RD_THREAD   26'h000_009E
`define PLM_FN_WR_THREAD   26'h000_009F
`define PLM_FN_PRIV_LIMIT  26'h000_0080

// ==========================================================
// Reset values and field limits
`define PLM_MODE_KERNEL    2'h0
`define PLM_HALT_CONSOLE   1'h0
`define PLM_PC_ZERO        64'h0000_0000_0000_0000

`endif

/* plm_pkg.sv */
// Types for the privileged library mode unit
package plm_pkg;
   // ==========================================================
   // Sequencer states, one-hot
   typedef enum logic [4:0]
   {
      PLM_RUN    = 5'h01,
      PLM_DRAIN  = 5'h02,
      PLM_HALTED = 5'h04,
      PLM_IFLUSH = 5'h08,
      PLM_LIB    = 5'h10
   } plm_state_t;

   // Class of a decoded instruction
   typedef enum logic [2:0]
   {
      PLM_C_NONE    = 3'h0,
      PLM_C_RESV    = 3'h1,
      PLM_C_CALLREC = 3'h2,
      PLM_C_DRAIN   = 3'h3,
      PLM_C_HALT    = 3'h4,
      PLM_C_IBAR    = 3'h5,
      PLM_C_CALLGEN = 3'h6
   } plm_class_t;
endpackage

/* plm_unit.sv */
// Privileged library mode sequencer: trap, entry, exit, drain, halt and barrier
`timescale 1ns/1ps
`include "plm_map.svh"

// Behaviour
// - Reserved opcodes trap outside library mode
// - Save state and dispatch into library mode
// - Library mode may read/write control registers
// - Exit loads PC, enables interrupts, mapping, drops privilege
// - Library mode: interrupts off, hw functions on
// - Fill flow left to library software
// - Context switch flow not in hardware
// - Decode breakpoint, bugcheck, generic_trap_call, thread calls
// - Drain traps if mode nonzero, else stalls
// - Outstanding aborts taken before later instructions
// - Completion: result, PC, or first-level store written
// - Drain ignores block remainder and final store
// - Halt stops issue, console or restart
// - Barrier resynchronises instruction cache
// - Unbarriered fetch may return old or new
module plm_unit
   import plm_pkg::*;
#(
   parameter int CR_ADDR_W = 8                    // Control register address width
)
(
   input  wire logic                 clk_sys_i,        // System clock
   input  wire logic                 rstn_i,           // Async reset, active low
   input  wire logic                 issue_valid_i,    // Instruction offered for issue
   input  wire logic [31:0]          issue_instr_i,    // Instruction word
   input  wire logic [63:0]          issue_pc_i,       // PC of the offered instruction
   input  wire logic [1:0]           current_mode_field_i, // Current processor mode
   input  wire logic                 older_pending_i,  // Earlier instructions not yet complete
   input  wire logic                 abort_pending_i,  // Abort signalled but not yet taken
   input  wire logic                 halt_action_i,    // 0 console, 1 restart
   input  wire logic                 icache_sync_done_i, // Instruction cache resync finished
   input  wire logic                 exit_req_i,       // Library code requests exit
   input  wire logic [63:0]          exit_pc_i,        // PC to load on exit
   input  wire logic [63:0]          cr_rdata_i,       // Control register read data
   input  wire logic                 restart_i,        // Leave halt state
   output logic                      issue_stall_o,    // Hold issue
   output logic                      illegal_trap_o,   // Illegal instruction trap pulse
   output logic                      priv_trap_o,      // Privileged instruction trap pulse
   output logic                      lib_enter_o,      // Dispatch into library mode pulse
   output logic [63:0]               saved_pc_o,       // PC saved at entry
   output logic [1:0]                saved_mode_o,     // Mode saved at entry
   output logic [25:0]               dispatch_fn_o,    // Function code dispatched
   output logic [2:0]                call_class_o,     // Class of dispatched call
   output logic                      lib_mode_o,       // In library mode
   output logic                      int_enable_o,     // Interrupts enabled
   output logic                      map_enable_o,     // Instruction-stream mapping enabled
   output logic                      hw_func_enable_o, // Implementation functions enabled
   output logic                      pc_load_o,        // Load PC pulse
   output logic [63:0]               pc_load_value_o,  // PC to load
   output logic                      cr_wr_o,          // Control register write strobe
   output logic                      cr_rd_o,          // Control register read strobe
   output logic [CR_ADDR_W-1:0]      cr_addr_o,        // Control register address
   output logic [63:0]               cr_wdata_o,       // Control register write data
   output logic [63:0]               cr_rdata_o,       // Captured read data
   output logic                      hw_op_o,          // Reserved op carried out pulse
   output logic                      icache_sync_o,    // Instruction cache resync request
   output logic                      console_enter_o,  // Enter console pulse
   output logic                      restart_seq_o,    // Start restart pulse
   output logic                      halted_o          // Processor halted
);

   // ==========================================================
   // Decode
   plm_state_t        state;          // Sequencer state
   plm_state_t        next_state;     // Next sequencer state
   plm_class_t        cls;            // Class of offered instruction
   logic [5:0]        opc;            // Major opcode
   logic [25:0]       fn;             // Call function field
   logic              resv_op;        // Reserved library opcode
   logic              take;           // Instruction accepted this cycle
   logic              in_lib;         // Library mode flag
   logic [63:0]       write_data;     // Data for control register writes

   // Field split of the offered instruction word
   assign opc     = issue_instr_i[31:26];
   assign fn      = issue_instr_i[25:0];
   assign in_lib  = (state == PLM_LIB);
   // Offers are accepted only while no multi-cycle operation stalls issue
   assign take    = issue_valid_i && (state == PLM_RUN || state == PLM_LIB);
   // Five major opcodes are held back for library code
   assign resv_op = (opc == `PLM_OP_RES_ZERO) || (opc == `PLM_OP_RES_ONE) ||
                    (opc == `PLM_OP_RES_TWO) || (opc == `PLM_OP_RES_THREE) ||
                    (opc == `PLM_OP_RES_FOUR);
   // Write data is the zero-extended function field
   assign write_data = {38'h0, fn};

   // Classify the offered instruction
   always_comb
   begin
      cls = PLM_C_NONE;
      // Reserved opcodes win over any call decode
      if (resv_op)
      begin
         cls = PLM_C_RESV;
      end
      else if (opc == `PLM_OP_CALL)
      begin
         case (fn)
            `PLM_FN_DRAIN:    cls = PLM_C_DRAIN;
            `PLM_FN_HALT:     cls = PLM_C_HALT;
            `PLM_FN_IBARRIER: cls = PLM_C_IBAR;
            `PLM_FN_BREAK, `PLM_FN_BUG_CHECK_TRAP_CALL, `PLM_FN_GENERIC_TRAP_CALL,
            `PLM_FN_RD_THREAD, `PLM_FN_WR_THREAD:
               cls = PLM_C_CALLREC;
            // Unlisted call functions still dispatch to library code
            default:          cls = PLM_C_CALLGEN;
         endcase
      end
   end

   // ==========================================================
   // Sequencer
   // Next state; refused offers leave the state alone
   always_comb
   begin
      next_state = state;
      case (state)
         // Offers are decoded only in normal running
         PLM_RUN:
         begin
            if (take)
            begin
               case (cls)
                  PLM_C_DRAIN:
                     if (current_mode_field_i == `PLM_MODE_KERNEL)
                        next_state = PLM_DRAIN;
                  PLM_C_HALT:
                     if (current_mode_field_i == `PLM_MODE_KERNEL)
                        next_state = PLM_HALTED;
                  PLM_C_IBAR:    next_state = PLM_IFLUSH;
                  PLM_C_CALLREC,
                  PLM_C_CALLGEN:
                     if (fn >= `PLM_FN_PRIV_LIMIT ||
                         current_mode_field_i == `PLM_MODE_KERNEL)
                        next_state = PLM_LIB;
                  default:       next_state = PLM_RUN;
               endcase
            end
         end
         // Wait for earlier work to complete and aborts to be taken
         PLM_DRAIN:
            if (!older_pending_i && !abort_pending_i)
               next_state = PLM_RUN;
         // Stay halted until the restart input
         PLM_HALTED:
            if (restart_i)
               next_state = PLM_RUN;
         // Hold issue until the cache reports coherence
         PLM_IFLUSH:
            if (icache_sync_done_i)
               next_state = PLM_RUN;
         // Library code leaves in one transition
         PLM_LIB:
            if (exit_req_i)
               next_state = PLM_RUN;
         // Illegal state code recovers to normal running
         default: next_state = PLM_RUN;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         state <= PLM_RUN;
      else
         state <= next_state;
   end

   // Stall issue while any multi-cycle operation runs
   // Halted state stalls too, so nothing issues while stopped
   assign issue_stall_o = (state == PLM_DRAIN) || (state == PLM_HALTED) ||
                          (state == PLM_IFLUSH);

   // Mode outputs follow the state in one transition
   assign lib_mode_o       = in_lib;
   assign int_enable_o     = !in_lib;
   assign map_enable_o     = !in_lib;
   assign hw_func_enable_o = in_lib;
   assign halted_o         = (state == PLM_HALTED);
   assign icache_sync_o    = (state == PLM_IFLUSH);

   // ==========================================================
   // Trap pulses
   // Registered so that traps never glitch on decode changes
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         illegal_trap_o <= 1'b0;
         priv_trap_o    <= 1'b0;
         hw_op_o        <= 1'b0;
      end
      else
      begin
         illegal_trap_o <= take && (cls == PLM_C_RESV) && !in_lib;
         hw_op_o        <= take && (cls == PLM_C_RESV) && in_lib;
         // Halt, drain and calls below the limit need kernel mode
         priv_trap_o    <= take && !in_lib && current_mode_field_i != `PLM_MODE_KERNEL &&
                           ((cls == PLM_C_DRAIN) || (cls == PLM_C_HALT) ||
                            ((cls == PLM_C_CALLGEN || cls == PLM_C_CALLREC) &&
                             fn < `PLM_FN_PRIV_LIMIT));
      end
   end

   // ==========================================================
   // Entry state save; fill and context switch flows run in library code
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lib_enter_o   <= 1'b0;
         saved_pc_o    <= `PLM_PC_ZERO;
         saved_mode_o  <= `PLM_MODE_KERNEL;
         dispatch_fn_o <= `PLM_FN_HALT;
         call_class_o  <= PLM_C_NONE;
      end
      else
      begin
         // Pulse on the edge that enters library mode
         lib_enter_o <= (state == PLM_RUN) && (next_state == PLM_LIB);
         if ((state == PLM_RUN) && (next_state == PLM_LIB))
         begin
            // Capture what library code needs to resume the caller
            saved_pc_o    <= issue_pc_i;
            saved_mode_o  <= current_mode_field_i;
            dispatch_fn_o <= fn;
            call_class_o  <= cls;
         end
      end
   end

   // ==========================================================
   // Exit: PC load together with mode change
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pc_load_o       <= 1'b0;
         pc_load_value_o <= `PLM_PC_ZERO;
      end
      else
      begin
         pc_load_o <= in_lib && exit_req_i;
         // Exit value is held until the next exit
         if (in_lib && exit_req_i)
            pc_load_value_o <= exit_pc_i;
      end
   end

   // ==========================================================
   // Control register access, library mode only
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cr_wr_o    <= 1'b0;
         cr_rd_o    <= 1'b0;
         cr_addr_o  <= '0;
         cr_wdata_o <= `PLM_PC_ZERO;
         cr_rdata_o <= `PLM_PC_ZERO;
      end
      else
      begin
         // Reserved op zero reads, one writes; address in low field bits
         cr_rd_o <= take && in_lib && (opc == `PLM_OP_RES_ZERO);
         cr_wr_o <= take && in_lib && (opc == `PLM_OP_RES_ONE);
         if (take && in_lib && (opc == `PLM_OP_RES_ZERO || opc == `PLM_OP_RES_ONE))
         begin
            cr_addr_o  <= fn[CR_ADDR_W-1:0];
            cr_wdata_o <= write_data;
         end
         // Read data is taken one cycle after the read strobe
         if (cr_rd_o)
            cr_rdata_o <= cr_rdata_i;
      end
   end

   // ==========================================================
   // Halt action pulses
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         console_enter_o <= 1'b0;
         restart_seq_o   <= 1'b0;
      end
      else
      begin
         // Only the edge that enters the halt state pulses
         // Halt action is the one set when the halt is taken
         console_enter_o <= (state == PLM_RUN) && (next_state == PLM_HALTED) &&
                            (halt_action_i == `PLM_HALT_CONSOLE);
         restart_seq_o   <= (state == PLM_RUN) && (next_state == PLM_HALTED) &&
                            (halt_action_i != `PLM_HALT_CONSOLE);
      end
   end

endmodule

/* plm_unit_asserts.sv */
// Concurrent checks on the privileged library mode sequencer ports
`timescale 1ns/1ps
`include "plm_map.svh"
module plm_unit_asserts
(
   input wire logic        clk_sys_i,
   input wire logic        rstn_i,
   input wire logic        issue_valid_i,
   input wire logic [31:0] issue_instr_i,
   input wire logic [63:0] issue_pc_i,
   input wire logic [1:0]  current_mode_field_i,
   input wire logic        older_pending_i,
   input wire logic        abort_pending_i,
   input wire logic        halt_action_i,
   input wire logic        exit_req_i,
   input wire logic [63:0] exit_pc_i,
   input wire logic        issue_stall_o,
   input wire logic        illegal_trap_o,
   input wire logic        priv_trap_o,
   input wire logic        lib_enter_o,
   input wire logic [63:0] saved_pc_o,
   input wire logic        lib_mode_o,
   input wire logic        int_enable_o,
   input wire logic        map_enable_o,
   input wire logic        hw_func_enable_o,
   input wire logic        pc_load_o,
   input wire logic [63:0] pc_load_value_o,
   input wire logic        icache_sync_o,
   input wire logic        console_enter_o,
   input wire logic        restart_seq_o,
   input wire logic        halted_o
);
   // ==========================================================
   // Decode helpers
   logic [25:0] fn;       // Call function code
   logic        resv;     // Reserved opcode offered
   logic        call;     // Call taken in normal mode
   logic        drain_st; // Stalled for abort drain
   assign fn = issue_instr_i[25:0];
   assign resv = issue_valid_i && (issue_instr_i[31:26] inside {`PLM_OP_RES_ZERO, `PLM_OP_RES_ONE,
                 `PLM_OP_RES_TWO, `PLM_OP_RES_THREE, `PLM_OP_RES_FOUR});
   assign call = issue_valid_i && !issue_stall_o && !lib_mode_o && issue_instr_i[31:26] == `PLM_OP_CALL;
   assign drain_st = issue_stall_o && !halted_o && !icache_sync_o;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   // ==========================================================
   // Rule checks
   a_resv_trap: assert property (resv && !issue_stall_o && !lib_mode_o |=> illegal_trap_o)
      else $error("reserved op outside library mode did not trap");
   a_resv_lib_ok: assert property (resv && lib_mode_o |=> !illegal_trap_o)
      else $error("reserved op trapped in library mode");
   a_lib_env: assert property (lib_mode_o |-> !int_enable_o && !map_enable_o && hw_func_enable_o)
      else $error("library mode environment wrong");
   a_exit_atomic: assert property (lib_mode_o && exit_req_i |=> pc_load_o && !lib_mode_o && int_enable_o
      && map_enable_o && pc_load_value_o == $past(exit_pc_i))
      else $error("exit transition incomplete");
   a_enter_save: assert property (call && fn >= `PLM_FN_PRIV_LIMIT && fn != `PLM_FN_IBARRIER |=>
      lib_enter_o && lib_mode_o && saved_pc_o == $past(issue_pc_i))
      else $error("call dispatch did not save pc");
   a_drain_priv: assert property (call && fn == `PLM_FN_DRAIN && current_mode_field_i != 2'h0 |=>
      priv_trap_o && !issue_stall_o)
      else $error("drain outside kernel mode did not trap");
   a_drain_enter: assert property (call && fn == `PLM_FN_DRAIN && current_mode_field_i == 2'h0 |=>
      issue_stall_o && !priv_trap_o)
      else $error("drain did not stall issue");
   a_drain_hold: assert property (drain_st && (older_pending_i || abort_pending_i) |=> issue_stall_o)
      else $error("drain released with work outstanding");
   a_drain_free: assert property (drain_st && !older_pending_i && !abort_pending_i |=> !issue_stall_o)
      else $error("drain did not release");
   a_halt_act: assert property (call && fn == `PLM_FN_HALT && current_mode_field_i == 2'h0 |=> halted_o
      && issue_stall_o && restart_seq_o == $past(halt_action_i) && console_enter_o != $past(halt_action_i))
      else $error("halt action wrong");
   a_ibar_sync: assert property (call && fn == `PLM_FN_IBARRIER |=>
      icache_sync_o && issue_stall_o && !lib_enter_o)
      else $error("barrier did not resync");

   // Main scenarios seen
   c_lib_exit: cover property (lib_mode_o && exit_req_i);
   c_drain: cover property (drain_st && older_pending_i);
   c_halt: cover property (halted_o && restart_seq_o);
endmodule

bind plm_unit plm_unit_asserts u_chk (.*);

/* tb_privileged_mode_support.sv */
// Self-checking bench for the privileged library mode sequencer
`timescale 1ns/1ps
`include "plm_map.svh"
module tb_privileged_mode_support
   import plm_pkg::*;
;
   // Ordinary case: word, mode, expected {illegal, priv, enter}
   typedef struct packed {logic [31:0] w; logic [1:0] m; logic [2:0] e;} plm_row_t;
   logic clk_sys_i, rstn_i, issue_valid_i, older_pending_i, abort_pending_i, halt_action_i;
   logic icache_sync_done_i, exit_req_i, restart_i;
   logic [31:0] issue_instr_i;
   logic [63:0] issue_pc_i, exit_pc_i, cr_rdata_i, saved_pc_o, pc_load_value_o, cr_wdata_o, cr_rdata_o;
   logic [1:0] current_mode_field_i, saved_mode_o;
   logic issue_stall_o, illegal_trap_o, priv_trap_o, lib_enter_o, lib_mode_o, int_enable_o, map_enable_o;
   logic hw_func_enable_o, pc_load_o, cr_wr_o, cr_rd_o, hw_op_o, icache_sync_o, console_enter_o;
   logic restart_seq_o, halted_o;
   logic [25:0] dispatch_fn_o;
   logic [2:0] call_class_o;
   logic [7:0] cr_addr_o;
   int n_mismatch = 0;
   int tests_run = 0;
   plm_row_t rows [12] = '{
      '{{`PLM_OP_RES_ZERO, 26'h000_0000}, 2'h1, 3'h4}, '{{`PLM_OP_RES_ONE, 26'h000_0001}, 2'h0, 3'h4},
      '{{`PLM_OP_RES_TWO, 26'h000_0002}, 2'h2, 3'h4}, '{{`PLM_OP_RES_THREE, 26'h000_0003}, 2'h3, 3'h4},
      '{{`PLM_OP_RES_FOUR, 26'h3FF_FFFF}, 2'h1, 3'h4}, '{{`PLM_OP_CALL, `PLM_FN_BREAK}, 2'h3, 3'h1},
      '{{`PLM_OP_CALL, `PLM_FN_BUG_CHECK_TRAP_CALL}, 2'h0, 3'h1}, '{{`PLM_OP_CALL, `PLM_FN_GENERIC_TRAP_CALL}, 2'h2, 3'h1},
      '{{`PLM_OP_CALL, `PLM_FN_RD_THREAD}, 2'h3, 3'h1}, '{{`PLM_OP_CALL, `PLM_FN_WR_THREAD}, 2'h1, 3'h1},
      '{{`PLM_OP_CALL, `PLM_FN_HALT}, 2'h2, 3'h2}, '{{`PLM_OP_CALL, `PLM_FN_DRAIN}, 2'h1, 3'h2}};

   plm_unit DUT (.*);

   // ==========================================================
   // Clock, 100 ns period
   initial
   begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // Count and report one comparison
   task automatic chk(input logic c, input string m);
      tests_run++;
      if (c !== 1'b1)
      begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   // Offer one instruction for a single cycle, then look after the take edge
   task automatic issue(input logic [31:0] w, input logic [1:0] m);
      @(posedge clk_sys_i);
      issue_valid_i <= 1'b1;
      issue_instr_i <= w;
      issue_pc_i <= {w, 32'h0000_1000};
      current_mode_field_i <= m;
      @(posedge clk_sys_i);
      issue_valid_i <= 1'b0;
      @(negedge clk_sys_i);
   endtask

   // Request exit from library mode
   task automatic leave(input logic [63:0] p);
      @(posedge clk_sys_i);
      exit_req_i <= 1'b1;
      exit_pc_i <= p;
      @(posedge clk_sys_i);
      exit_req_i <= 1'b0;
      @(negedge clk_sys_i);
   endtask

   // Verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      repeat (5000) @(posedge clk_sys_i);
      n_mismatch++;
      results();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      {rstn_i, issue_valid_i, older_pending_i, abort_pending_i, halt_action_i} = '0;
      {icache_sync_done_i, exit_req_i, restart_i, issue_instr_i, current_mode_field_i} = '0;
      {issue_pc_i, exit_pc_i} = '0;
      cr_rdata_i = 64'h0123_4567_89AB_CDEF;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(negedge clk_sys_i);
      chk(!lib_mode_o && int_enable_o && map_enable_o && !halted_o && !issue_stall_o, "reset state");
      foreach (rows[i])
      begin
         issue(rows[i].w, rows[i].m);
         chk({illegal_trap_o, priv_trap_o, lib_enter_o} === rows[i].e, "row pulses");
         if (rows[i].e[0])
         begin
            chk(dispatch_fn_o === rows[i].w[25:0] && call_class_o === PLM_C_CALLREC, "recognise");
            chk(saved_pc_o === {rows[i].w, 32'h0000_1000}, "saved pc");
            chk(saved_mode_o === rows[i].m, "saved mode");
            leave(64'h0000_0000_0000_2000);
         end
      end
      // Library mode: control registers, reserved ops, exit
      issue({`PLM_OP_CALL, `PLM_FN_BREAK}, 2'h0);
      chk(!int_enable_o && !map_enable_o && hw_func_enable_o, "lib env");
      issue({`PLM_OP_RES_ZERO, 26'h000_0042}, 2'h0);
      chk(cr_rd_o === 1'b1 && illegal_trap_o === 1'b0, "cr read");
      issue({`PLM_OP_RES_ONE, 26'h2A5_5A3C}, 2'h0);
      chk(cr_wr_o === 1'b1 && cr_addr_o === 8'h3C && cr_wdata_o === 64'h0000_0000_02A5_5A3C, "cr write");
      chk(cr_rdata_o === 64'h0123_4567_89AB_CDEF, "cr read data");
      issue({`PLM_OP_RES_TWO, 26'h000_0007}, 2'h0);
      chk(hw_op_o === 1'b1 && illegal_trap_o === 1'b0, "hw op");
      issue({`PLM_OP_CALL, `PLM_FN_DRAIN}, 2'h0);
      chk(lib_mode_o === 1'b1 && issue_stall_o === 1'b0 && lib_enter_o === 1'b0, "call ignored in lib");
      leave(64'h1234_5678_9ABC_DEF0);
      chk(pc_load_o && pc_load_value_o === 64'h1234_5678_9ABC_DEF0 && !lib_mode_o && int_enable_o, "exit");
      // Drain with work outstanding, a refused offer while stalled
      @(posedge clk_sys_i);
      older_pending_i <= 1'b1;
      abort_pending_i <= 1'b1;
      issue({`PLM_OP_CALL, `PLM_FN_DRAIN}, 2'h0);
      chk(issue_stall_o === 1'b1 && priv_trap_o === 1'b0, "drain stall");
      issue({`PLM_OP_RES_ZERO, 26'h000_0000}, 2'h0);
      chk(issue_stall_o === 1'b1 && illegal_trap_o === 1'b0, "held while draining");
      @(posedge clk_sys_i);
      older_pending_i <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk(issue_stall_o === 1'b1, "abort still pending");
      @(posedge clk_sys_i);
      abort_pending_i <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk(issue_stall_o === 1'b0, "drain done");
      // Halt with both actions, then restart
      for (int a = 0; a < 2; a++)
      begin
         @(posedge clk_sys_i);
         halt_action_i <= a[0];
         issue({`PLM_OP_CALL, `PLM_FN_HALT}, 2'h0);
         chk(halted_o && issue_stall_o && console_enter_o === !a[0] && restart_seq_o === a[0], "halt");
         @(posedge clk_sys_i);
         restart_i <= 1'b1;
         @(posedge clk_sys_i);
         restart_i <= 1'b0;
         @(negedge clk_sys_i);
         chk(halted_o === 1'b0 && issue_stall_o === 1'b0, "restart");
      end
      // Unprivileged barrier from user mode
      issue({`PLM_OP_CALL, `PLM_FN_IBARRIER}, 2'h3);
      chk(icache_sync_o && issue_stall_o && !lib_mode_o && !priv_trap_o, "barrier");
      @(posedge clk_sys_i);
      icache_sync_done_i <= 1'b1;
      @(posedge clk_sys_i);
      icache_sync_done_i <= 1'b0;
      @(negedge clk_sys_i);
      chk(icache_sync_o === 1'b0 && issue_stall_o === 1'b0, "barrier done");
      // Reset in mid-run from library mode, then a trap right after release
      issue({`PLM_OP_CALL, `PLM_FN_GENERIC_TRAP_CALL}, 2'h0);
      chk(lib_mode_o === 1'b1, "lib before reset");
      @(posedge clk_sys_i);
      rstn_i <= 1'b0;
      @(negedge clk_sys_i);
      chk(!lib_mode_o && int_enable_o && map_enable_o && !issue_stall_o && saved_pc_o === 64'h0, "mid-run reset");
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      issue({`PLM_OP_RES_FOUR, 26'h000_0000}, 2'h0);
      chk(illegal_trap_o === 1'b1 && hw_op_o === 1'b0, "trap after reset");
      results();
   end
endmodule
